// [csb_pkg.sv]
// Constants for the core special-function register bank: map, resets, masks.
// Assumes one system clock and a core that drives the byte and bit SFR ports.
package csb_pkg;

  localparam int GEN_COUNT = 17;
  localparam logic [4:0] GEN_MISS = 5'h1F;

  // Plain read/write registers held in the common array
  localparam logic [7:0] GEN_ADDR [GEN_COUNT] = '{
    8'h80, 8'h82, 8'h83, 8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D,
    8'h8E, 8'h90, 8'h92, 8'h93, 8'h94, 8'h95, 8'h96, 8'h97};
  localparam logic [7:0] GEN_RESET [GEN_COUNT] = '{
    8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  // Writable bits; the rest hold their reset value
  localparam logic [7:0] GEN_MASK [GEN_COUNT] = '{
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'h18, 8'hDF, 8'h33, 8'h3F, 8'h30, 8'hFF, 8'hBF, 8'h07};
  localparam int GEN_IDX_P0 = 0;
  localparam int GEN_IDX_DPL = 1;
  localparam int GEN_IDX_DPH = 2;
  localparam int GEN_IDX_P1 = 10;

  // Registers with their own behaviour
  localparam logic [7:0] ADDR_STACK_TOP_POINTER = 8'h81;
  localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
  localparam logic [7:0] ADDR_SERIAL_CONTROL = 8'h98;
  localparam logic [7:0] ADDR_POWER_MONITOR = 8'hA3;
  localparam logic [7:0] ADDR_RESET_STRAPS = 8'hA5;
  localparam logic [7:0] ADDR_PRIMARY_OPERAND = 8'hE0;
  localparam logic [7:0] ADDR_SECONDARY_OPERAND = 8'hF0;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'hFA;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'hFB;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'hFC;

  localparam logic [7:0] RST_STACK_TOP_POINTER = 8'h07;
  localparam logic [7:0] RST_SERIAL_CONTROL = 8'h00;
  localparam logic [7:0] RST_OPERAND = 8'h00;
  localparam logic [7:0] RST_POWER_CONTROL = 8'h10;
  localparam logic [7:0] MASK_POWER_CONTROL = 8'hDF;
  localparam logic [7:0] MASK_POWER_MONITOR = 8'hD8;
  localparam logic [7:0] MASK_RESET_STRAPS = 8'h82;

  // Field positions
  localparam int POWER_ON_FLAG_BIT = 4;
  localparam int BROWNOUT_DETECT_ENABLE_BIT = 7;
  localparam int BROWNOUT_LEVEL_SELECT_BIT = 6;
  localparam int BROWNOUT_RESET_ENABLE_BIT = 4;
  localparam int BROWNOUT_FLAG_BIT = 3;
  localparam int WATCHDOG_ENABLE_BIT = 7;
  localparam int BOOT_SELECT_BIT = 1;

  // Interrupt event bits
  localparam int IRQ_WIDTH = 3;
  localparam int IRQ_STACK_WRAP = 0;
  localparam int IRQ_DIVIDE_ZERO = 1;
  localparam int IRQ_BROWNOUT = 2;

endpackage

// [csb_core_sfr_bank.sv]
// Core SFR bank: operand registers, stack pointer and lower SFR map decode.
// Assumes all inputs come from logic on the same clock; powerOnReset is held
// high with rst, for at least one clock edge, only on a power-on reset.
`timescale 1ns/1ps
module csb_core_sfr_bank
  import csb_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic powerOnReset,
  input wire logic [7:0] configWordTwo,
  input wire logic cfgWatchdogEnable,
  input wire logic cfgBootSelect,
  input wire logic brownoutDetected,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrWrEn,
  input wire logic sfrRdEn,
  output logic [7:0] sfrRdData,
  input wire logic [7:0] bitAddr,
  input wire logic bitWrVal,
  input wire logic bitWrEn,
  input wire logic bitRdEn,
  output logic bitRdData,
  input wire logic pushReq,
  input wire logic [7:0] pushData,
  input wire logic popReq,
  output logic stackWrEn,
  output logic [7:0] stackWrAddr,
  output logic [7:0] stackWrData,
  input wire logic multiplyOp,
  input wire logic divideOp,
  output logic mulDivOverflow,
  output logic [7:0] primaryOperand,
  output logic [7:0] secondaryOperand,
  output logic [7:0] stackTopPointer,
  output logic [7:0] powerControl,
  output logic [7:0] powerMonitor,
  output logic watchdogEnable,
  output logic bootSelect,
  output logic irq
);
  import csb_pkg::*;

  // Find the common-array slot of a byte address
  function automatic logic [4:0] genIndex(input logic [7:0] addr);
    logic [4:0] idx;
    idx = GEN_MISS;
    for (int i = 0; i < GEN_COUNT; i++) begin
      if (GEN_ADDR[i] == addr) begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction

  // Masked update: reserved bits never take software data
  function automatic logic [7:0] maskedWrite(input logic [7:0] cur, input logic [7:0] val,
                                             input logic [7:0] mask);
    return (cur & ~mask) | (val & mask);
  endfunction

  logic [7:0] genReg [GEN_COUNT];
  logic [7:0] serialControl_reg;
  logic [7:0] powerLow_reg;
  logic powerOnFlag_reg;
  logic [7:0] powerNow;
  logic [7:0] irqStatus_reg;
  logic [7:0] irqEnable_reg;
  logic [7:0] powerMonitor_reg;
  logic [7:0] resetStraps_reg;
  logic [7:0] wrTarget;
  logic wrAny;
  logic [7:0] bitByteAddr;
  logic bitSpace;
  logic [7:0] rdByte;
  logic [7:0] bitRdByte;
  logic [15:0] product;
  logic stackWrap;
  logic divZero;
  logic brownoutSet;
  logic [IRQ_WIDTH-1:0] irqEvents;

  // A bit address with its top bit set names bit [2:0] of SFR [7:3]*8
  assign bitSpace = bitAddr[7];
  assign bitByteAddr = {bitAddr[7:3], 3'h0};
  assign wrAny = sfrWrEn | (bitWrEn & bitSpace);
  assign wrTarget = sfrWrEn ? sfrAddr : bitByteAddr;

  // Value software writes: whole byte, or current byte with one bit replaced
  function automatic logic [7:0] writeValue(input logic [7:0] cur, input logic byteWr,
                                            input logic [7:0] data, input logic [2:0] pos,
                                            input logic val);
    logic [7:0] res;
    res = cur;
    if (byteWr) begin
      res = data;
    end else begin
      res[pos] = val;
    end
    return res;
  endfunction

  // Plain registers; writes land on the edge ending the addressed cycle
  for (genvar g = 0; g < GEN_COUNT; g++) begin : gen_plain
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        genReg[g] <= GEN_RESET[g];
      end else if (wrAny && wrTarget == GEN_ADDR[g]) begin
        genReg[g] <= maskedWrite(genReg[g],
          writeValue(genReg[g], sfrWrEn, sfrWrData, bitAddr[2:0], bitWrVal),
          GEN_MASK[g]);
      end
    end
  end

  // Serial control is the only bit-addressable slot between 0x90 and 0xE0
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      serialControl_reg <= RST_SERIAL_CONTROL;
    end else if (wrAny && wrTarget == ADDR_SERIAL_CONTROL) begin
      serialControl_reg <= writeValue(serialControl_reg, sfrWrEn, sfrWrData, bitAddr[2:0],
                                      bitWrVal);
    end
  end

  // Stack pointer: push increments before the store, pop decrements after
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stackTopPointer <= RST_STACK_TOP_POINTER;
    end else if (pushReq) begin
      stackTopPointer <= stackTopPointer + 8'h01;
    end else if (popReq) begin
      stackTopPointer <= stackTopPointer - 8'h01;
    end else if (sfrWrEn && sfrAddr == ADDR_STACK_TOP_POINTER) begin
      stackTopPointer <= sfrWrData;
    end
  end

  // Scratch-pad store issued one cycle later at the already-incremented address
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stackWrEn <= 1'b0;
      stackWrAddr <= 8'h00;
      stackWrData <= 8'h00;
    end else begin
      stackWrEn <= pushReq;
      if (pushReq) begin
        stackWrAddr <= stackTopPointer + 8'h01;
        stackWrData <= pushData;
      end
    end
  end

  assign product = primaryOperand * secondaryOperand;
  assign divZero = divideOp && secondaryOperand == 8'h00;
  assign stackWrap = pushReq && stackTopPointer == 8'hFF;

  // Primary operand; arithmetic results take priority over software writes
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      primaryOperand <= RST_OPERAND;
    end else if (multiplyOp) begin
      primaryOperand <= product[7:0];
    end else if (divideOp) begin
      if (!divZero) begin
        primaryOperand <= primaryOperand / secondaryOperand;
      end
    end else if (wrAny && wrTarget == ADDR_PRIMARY_OPERAND) begin
      primaryOperand <= writeValue(primaryOperand, sfrWrEn, sfrWrData, bitAddr[2:0], bitWrVal);
    end
  end

  // Secondary operand: high product byte or remainder, else plain read/write
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      secondaryOperand <= RST_OPERAND;
    end else if (multiplyOp) begin
      secondaryOperand <= product[15:8];
    end else if (divideOp) begin
      if (!divZero) begin
        secondaryOperand <= primaryOperand % secondaryOperand;
      end
    end else if (wrAny && wrTarget == ADDR_SECONDARY_OPERAND) begin
      secondaryOperand <= writeValue(secondaryOperand, sfrWrEn, sfrWrData, bitAddr[2:0],
                                     bitWrVal);
    end
  end

  // Overflow: product above one byte, or divide by zero (operands then kept)
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mulDivOverflow <= 1'b0;
    end else if (multiplyOp) begin
      mulDivOverflow <= product[15:8] != 8'h00;
    end else if (divideOp) begin
      mulDivOverflow <= divZero;
    end
  end

  // Power control, volatile bits: cleared on every reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      powerLow_reg <= RST_POWER_CONTROL & ~(8'h01 << POWER_ON_FLAG_BIT);
    end else if (sfrWrEn && sfrAddr == ADDR_POWER_CONTROL) begin
      powerLow_reg <= maskedWrite(powerLow_reg, sfrWrData, MASK_POWER_CONTROL);
    end
  end

  // Retained state has no async reset: a non power-on reset must leave it
  // alone, so only the clocked power-on load touches it.
  always_ff @(posedge clock) begin
    if (powerOnReset) begin
      powerOnFlag_reg <= 1'b1;
    end else if (!rst && sfrWrEn && sfrAddr == ADDR_POWER_CONTROL) begin
      powerOnFlag_reg <= sfrWrData[POWER_ON_FLAG_BIT];
    end
  end

  // Volatile bits beside the retained power-on flag
  assign powerNow = (powerLow_reg & ~(8'h01 << POWER_ON_FLAG_BIT))
    | ({7'h00, powerOnFlag_reg} << POWER_ON_FLAG_BIT);

  assign brownoutSet = brownoutDetected && powerMonitor_reg[BROWNOUT_DETECT_ENABLE_BIT];

  // Brownout settings: loaded from config word two at power-on only
  always_ff @(posedge clock) begin
    if (powerOnReset) begin
      powerMonitor_reg <= (configWordTwo & MASK_POWER_MONITOR & ~(8'h01 << BROWNOUT_FLAG_BIT))
        | ({7'h00, configWordTwo[BROWNOUT_DETECT_ENABLE_BIT]} << BROWNOUT_FLAG_BIT);
    end else if (!rst) begin
      if (sfrWrEn && sfrAddr == ADDR_POWER_MONITOR) begin
        powerMonitor_reg <= maskedWrite(powerMonitor_reg, sfrWrData, MASK_POWER_MONITOR);
      end
      if (brownoutSet) begin
        powerMonitor_reg[BROWNOUT_FLAG_BIT] <= 1'b1; // Detection wins over a clear
      end
    end
  end

  // Watchdog enable and boot select: inverted config at power-on, kept over other resets
  always_ff @(posedge clock) begin
    if (powerOnReset) begin
      resetStraps_reg <= 8'h00;
      resetStraps_reg[WATCHDOG_ENABLE_BIT] <= ~cfgWatchdogEnable;
      resetStraps_reg[BOOT_SELECT_BIT] <= ~cfgBootSelect;
    end else if (!rst && sfrWrEn && sfrAddr == ADDR_RESET_STRAPS) begin
      resetStraps_reg <= maskedWrite(resetStraps_reg, sfrWrData, MASK_RESET_STRAPS);
    end
  end

  always_ff @(posedge clock) begin
    powerMonitor <= powerMonitor_reg;
    powerControl <= powerNow;
    watchdogEnable <= resetStraps_reg[WATCHDOG_ENABLE_BIT];
    bootSelect <= resetStraps_reg[BOOT_SELECT_BIT];
  end

  assign irqEvents = {brownoutSet, divZero, stackWrap};

  // Sticky status: an event in the clear cycle stays set
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irqStatus_reg <= 8'h00;
    end else begin
      for (int i = 0; i < IRQ_WIDTH; i++) begin
        if (irqEvents[i]) begin
          irqStatus_reg[i] <= 1'b1;
        end else if (sfrWrEn && sfrAddr == ADDR_IRQ_CLEAR && sfrWrData[i]) begin
          irqStatus_reg[i] <= 1'b0;
        end
      end
    end
  end

  // Interrupt enables and registered level output
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irqEnable_reg <= 8'h00;
      irq <= 1'b0;
    end else begin
      if (sfrWrEn && sfrAddr == ADDR_IRQ_ENABLE) begin
        irqEnable_reg <= sfrWrData & 8'((1 << IRQ_WIDTH) - 1);
      end
      irq <= |(irqStatus_reg & irqEnable_reg);
    end
  end

  // Read decode; every unlisted address answers zero with no side effect
  function automatic logic [7:0] readMux(input logic [7:0] addr);
    logic [4:0] idx;
    logic [7:0] res;
    idx = genIndex(addr);
    res = 8'h00;
    if (idx != GEN_MISS) begin
      res = genReg[idx];
    end else begin
      unique case (addr)
        ADDR_STACK_TOP_POINTER: res = stackTopPointer;
        ADDR_POWER_CONTROL: res = powerNow;
        ADDR_SERIAL_CONTROL: res = serialControl_reg;
        ADDR_POWER_MONITOR: res = powerMonitor_reg;
        ADDR_RESET_STRAPS: res = resetStraps_reg;
        ADDR_PRIMARY_OPERAND: res = primaryOperand;
        ADDR_SECONDARY_OPERAND: res = secondaryOperand;
        ADDR_IRQ_STATUS: res = irqStatus_reg;
        ADDR_IRQ_ENABLE: res = irqEnable_reg;
        default: res = 8'h00;
      endcase
    end
    return res;
  endfunction

  assign rdByte = readMux(sfrAddr);
  assign bitRdByte = readMux(bitByteAddr);

  // Read data stands one cycle after the strobe and only then
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sfrRdData <= 8'h00;
      bitRdData <= 1'b0;
    end else begin
      sfrRdData <= sfrRdEn ? rdByte : 8'h00;
      bitRdData <= bitRdEn && bitSpace && bitRdByte[bitAddr[2:0]];
    end
  end

endmodule // csb_core_sfr_bank

// [csb_checker.sv]
// Checker for the core SFR bank: timing relations seen at the bank's ports.
// Assumes it is bound to csb_core_sfr_bank; the bank has one clock domain.
`timescale 1ns/1ps
module csb_checker (
  input wire logic clock,
  input wire logic rst,
  input wire logic powerOnReset,
  input wire logic [7:0] configWordTwo,
  input wire logic cfgWatchdogEnable,
  input wire logic cfgBootSelect,
  input wire logic [7:0] sfrAddr,
  input wire logic sfrRdEn,
  input wire logic [7:0] sfrRdData,
  input wire logic pushReq,
  input wire logic [7:0] pushData,
  input wire logic stackWrEn,
  input wire logic [7:0] stackWrAddr,
  input wire logic [7:0] stackWrData,
  input wire logic multiplyOp,
  input wire logic mulDivOverflow,
  input wire logic [7:0] primaryOperand,
  input wire logic [7:0] secondaryOperand,
  input wire logic [7:0] stackTopPointer,
  input wire logic [7:0] powerControl,
  input wire logic [7:0] powerMonitor,
  input wire logic watchdogEnable,
  input wire logic bootSelect
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // Power-on reset held long enough for the retained bits to load
  sequence s_por_hold;
    (rst && powerOnReset)[*3];
  endsequence
  // Any other reset, seen over two edges
  sequence s_warm_hold;
    (rst && !powerOnReset)[*2];
  endsequence

  // Stack, read port and operand relations; the reset ones judge reset itself
  a_stack_reset_value: assert property ($fell(rst) |-> stackTopPointer == 8'h07)
    else $error("stack pointer not seven after reset");
  a_push_address: assert property (
    pushReq |=> stackWrEn && stackWrAddr == $past(stackTopPointer) + 8'h01)
    else $error("push store not at advanced pointer");
  a_push_pointer: assert property (
    pushReq |=> stackTopPointer == stackWrAddr && stackWrData == $past(pushData))
    else $error("push pointer or data wrong");
  a_store_cause: assert property (stackWrEn |-> $past(pushReq))
    else $error("store without push");
  a_unlisted_zero: assert property (
    sfrRdEn && sfrAddr inside {[8'h84:8'h86], 8'h91} |=> sfrRdData == 8'h00)
    else $error("unlisted address read not zero");
  a_idle_read_zero: assert property (!sfrRdEn |=> sfrRdData == 8'h00)
    else $error("read data outside read cycle");
  a_mul_product: assert property (multiplyOp |=>
    {secondaryOperand, primaryOperand} ==
    {8'h00, $past(primaryOperand)} * {8'h00, $past(secondaryOperand)} &&
    mulDivOverflow == (secondaryOperand != 8'h00))
    else $error("multiply result wrong");
  a_retain_other: assert property (@(posedge clock) disable iff (1'b0)
    s_warm_hold |=> $stable(powerMonitor) && $stable(watchdogEnable) &&
    $stable(bootSelect) && $stable(powerControl[4]))
    else $error("retained bits changed by other reset");
  a_por_straps: assert property (@(posedge clock) disable iff (1'b0)
    s_por_hold |-> watchdogEnable == !cfgWatchdogEnable &&
    bootSelect == !cfgBootSelect && powerControl == 8'h10)
    else $error("power-on straps wrong");
  a_por_brownout: assert property (@(posedge clock) disable iff (1'b0)
    s_por_hold |-> powerMonitor ==
    {configWordTwo[7:6], 1'b0, configWordTwo[4], configWordTwo[7], 3'b000})
    else $error("power-on brownout bits wrong");
endmodule // csb_checker

// [csb_scratchpad.sv]
// Core-side scratch-pad model: keeps every byte the bank stacks.
// Assumes stores arrive as one-cycle strobes on the bank's clock.
`timescale 1ns/1ps
module csb_scratchpad (
  input wire logic clock,
  input wire logic wrEn,
  input wire logic [7:0] wrAddr,
  input wire logic [7:0] wrData
);
  logic [7:0] mem [256];

  // Store lands where the bank already moved the pointer to
  always_ff @(posedge clock) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end
endmodule // csb_scratchpad

// [csb_core_sfr_bank_tb.sv]
// Testbench for the core SFR bank: register map, bit access, stack,
// operand arithmetic, interrupts, power-on and other resets.
// Assumes the checker and scratch-pad model are compiled before it.
`timescale 1ns/1ps
module csb_core_sfr_bank_tb;
  typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] e;} csb_row_s;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic powerOnReset = 1'b1;
  logic [7:0] configWordTwo = 8'hD0;
  logic cfgWatchdogEnable = 1'b1;
  logic cfgBootSelect = 1'b0;
  logic brownoutDetected = 1'b0;
  logic [7:0] sfrAddr = 8'h00, sfrWrData = 8'h00, bitAddr = 8'h00, pushData = 8'h00;
  logic sfrWrEn = 1'b0, sfrRdEn = 1'b0, bitWrVal = 1'b0, bitWrEn = 1'b0, bitRdEn = 1'b0;
  logic pushReq = 1'b0, popReq = 1'b0, multiplyOp = 1'b0, divideOp = 1'b0;
  logic [7:0] sfrRdData, stackWrAddr, stackWrData, primaryOperand, secondaryOperand;
  logic [7:0] stackTopPointer, powerControl, powerMonitor, v;
  logic bitRdData, stackWrEn, mulDivOverflow, watchdogEnable, bootSelect, irq;
  int nMismatch = 0;
  int nCompared = 0;
  // Address, byte written, byte read back; reserved bits must not move
  csb_row_s rows [15] = '{
    '{8'h80, 8'h5A, 8'h5A}, '{8'h82, 8'hA5, 8'hA5}, '{8'h83, 8'h3C, 8'h3C},
    '{8'h88, 8'hC3, 8'hC3}, '{8'h8E, 8'hFF, 8'h18}, '{8'h90, 8'h00, 8'h20},
    '{8'h92, 8'hFF, 8'h33}, '{8'h94, 8'hFF, 8'h30}, '{8'h96, 8'hFF, 8'hBF},
    '{8'h97, 8'hFF, 8'h07}, '{8'h98, 8'hFF, 8'hFF}, '{8'h87, 8'h00, 8'h00},
    '{8'h84, 8'h77, 8'h00}, '{8'hFC, 8'hFF, 8'h00}, '{8'hF0, 8'hC3, 8'hC3}};

  csb_core_sfr_bank u_dut (.clock, .rst, .powerOnReset, .configWordTwo, .cfgWatchdogEnable,
    .cfgBootSelect, .brownoutDetected, .sfrAddr, .sfrWrData, .sfrWrEn, .sfrRdEn, .sfrRdData,
    .bitAddr, .bitWrVal, .bitWrEn, .bitRdEn, .bitRdData, .pushReq, .pushData, .popReq,
    .stackWrEn, .stackWrAddr, .stackWrData, .multiplyOp, .divideOp, .mulDivOverflow,
    .primaryOperand, .secondaryOperand, .stackTopPointer, .powerControl, .powerMonitor,
    .watchdogEnable, .bootSelect, .irq);
  csb_scratchpad u_ram (.clock, .wrEn(stackWrEn), .wrAddr(stackWrAddr), .wrData(stackWrData));

  // Free-running 40 MHz system clock
  always #12.5 clock = ~clock;

  task automatic chk8(string n, logic [7:0] e, logic [7:0] g);
    nCompared++;
    if (g !== e) begin
      nMismatch++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // One-cycle operation strobe {divide, multiply, pop, push}, data beside it
  task automatic op(logic [3:0] m, logic [7:0] pd);
    @(posedge clock);
    {divideOp, multiplyOp, popReq, pushReq} <= m;
    pushData <= pd;
    @(posedge clock);
    {divideOp, multiplyOp, popReq, pushReq} <= 4'h0;
    #1;
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // Bus tasks: everything changes just after an edge and holds to the next
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clock);
    sfrAddr <= a;
    sfrWrData <= d;
    sfrWrEn <= 1'b1;
    @(posedge clock);
    sfrWrEn <= 1'b0;
    #1;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    sfrAddr <= a;
    sfrRdEn <= 1'b1;
    @(posedge clock);
    sfrRdEn <= 1'b0;
    #1;
    d = sfrRdData;
  endtask
  task automatic bw(logic [7:0] a, logic b);
    @(posedge clock);
    bitAddr <= a;
    bitWrVal <= b;
    bitWrEn <= 1'b1;
    @(posedge clock);
    bitWrEn <= 1'b0;
    #1;
  endtask
  task automatic wrapUp();
    $display("mismatches %0d comparisons %0d", nMismatch, nCompared);
    if (nMismatch == 0 && nCompared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Main sequence: power-on reset, table loop, then the awkward cases
  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    powerOnReset <= 1'b0;
    tick(1);
    chk8("pointer", 8'h07, stackTopPointer);
    chk8("power control", 8'h10, powerControl);
    chk8("brownout bits", 8'hD8, powerMonitor);
    chk8("straps", 8'h01, {6'h00, watchdogEnable, bootSelect});
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, v);
      chk8("table read", rows[i].e, v);
    end
    bw(8'h8B, 1'b1);
    bw(8'h8F, 1'b0);
    rd(8'h88, v);
    chk8("bit modify", 8'h4B, v);
    @(posedge clock);
    bitAddr <= 8'h8E;
    bitRdEn <= 1'b1;
    @(posedge clock);
    bitRdEn <= 1'b0;
    #1;
    chk8("bit read", 8'h01, {7'h00, bitRdData});
    bw(8'hE7, 1'b1);
    chk8("operand bit", 8'h80, primaryOperand);
    // Two pushes back to back, then a pop
    @(posedge clock);
    pushData <= 8'h11;
    pushReq <= 1'b1;
    @(posedge clock);
    pushData <= 8'h22;
    @(posedge clock);
    pushReq <= 1'b0;
    tick(2);
    chk8("first store", 8'h11, u_ram.mem[8]);
    chk8("second store", 8'h22, u_ram.mem[9]);
    op(4'h2, 8'h00);
    chk8("pop", 8'h08, stackTopPointer);
    // Pointer wrap raises an interrupt, then mask and clear
    wr(8'hFB, 8'h07);
    wr(8'h81, 8'hFF);
    op(4'h1, 8'hAB);
    tick(3);
    chk8("wrap store", 8'hAB, u_ram.mem[0]);
    chk8("irq", 8'h01, {7'h00, irq});
    rd(8'hFA, v);
    chk8("status", 8'h01, v);
    wr(8'hFB, 8'h00);
    tick(2);
    chk8("masked irq", 8'h00, {7'h00, irq});
    wr(8'hFC, 8'h01);
    rd(8'hFA, v);
    chk8("cleared", 8'h00, v);
    // Multiply, divide, divide by zero
    wr(8'hE0, 8'h10);
    wr(8'hF0, 8'h20);
    op(4'h4, 8'h00);
    chk8("product", 8'h02, secondaryOperand);
    chk8("mul flag", 8'h01, {7'h00, mulDivOverflow});
    wr(8'hE0, 8'h64);
    wr(8'hF0, 8'h07);
    op(4'h8, 8'h00);
    chk8("quotient", 8'h0E, primaryOperand);
    chk8("remainder", 8'h02, secondaryOperand);
    wr(8'hF0, 8'h00);
    op(4'h8, 8'h00);
    chk8("zero divide", 8'h01, {7'h00, mulDivOverflow});
    chk8("kept", 8'h0E, primaryOperand);
    // Other reset with new configuration: retained bits must hold
    @(posedge clock);
    cfgWatchdogEnable <= 1'b0;
    cfgBootSelect <= 1'b1;
    configWordTwo <= 8'h00;
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    tick(2);
    chk8("warm power", 8'h00, powerControl);
    chk8("warm brownout", 8'hD8, powerMonitor);
    chk8("warm straps", 8'h01, {6'h00, watchdogEnable, bootSelect});
    chk8("warm pointer", 8'h07, stackTopPointer);
    // Clear the brownout flag, then a detection sets it and its status bit
    wr(8'hA3, 8'hD0);
    @(posedge clock);
    brownoutDetected <= 1'b1;
    @(posedge clock);
    brownoutDetected <= 1'b0;
    tick(2);
    chk8("brownout flag", 8'hD8, powerMonitor);
    rd(8'hFA, v);
    chk8("brownout event", 8'h04, v & 8'h04);
    wrapUp();
  end

  // Hang guard, well beyond the roughly 140 cycles the tests take
  initial begin
    repeat (3000) @(posedge clock);
    nMismatch++;
    wrapUp();
  end
endmodule // csb_core_sfr_bank_tb

bind csb_core_sfr_bank csb_checker u_chk (.clock, .rst, .powerOnReset, .configWordTwo,
  .cfgWatchdogEnable, .cfgBootSelect, .sfrAddr, .sfrRdEn, .sfrRdData, .pushReq, .pushData,
  .stackWrEn, .stackWrAddr, .stackWrData, .multiplyOp, .mulDivOverflow, .primaryOperand,
  .secondaryOperand, .stackTopPointer, .powerControl, .powerMonitor, .watchdogEnable,
  .bootSelect);
